// ===== design/valve_travel_pkg.sv
// Constants of the valve travel alert monitor; its test side does not import them.
// Assumes travel values in hundredths of a percent of ranged travel.
package valve_travel_pkg;
   // ======================================================================
   // Clock and sample timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned NS_PER_S = 1_000_000_000;
   localparam int unsigned SAMPLE_PERIOD_NS = 1_000_000;
   localparam int unsigned SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned WDOG_TIMEOUT_MS = 100;
   localparam int unsigned NS_PER_MS = 1_000_000;
   localparam int unsigned WDOG_CYCLES = WDOG_TIMEOUT_MS * (NS_PER_MS / CLK_PERIOD_NS);

   // ======================================================================
   // Travel scale, in 0.01 % steps
   localparam int TRAVEL_ZERO = 0;
   localparam int TRAVEL_FULL = 10000;
   localparam int TRAVEL_MIN = -2500;
   localparam int TRAVEL_MAX = 12500;
   localparam int FRAC_BITS = 16;

   // ======================================================================
   // Setting ranges, in seconds
   localparam int DEV_TIME_MIN_S = 1;
   localparam int DEV_TIME_MAX_S = 60;
   localparam int RATE_TIME_MAX_S = 400;

   // Fixed point carrier for the filter and the rate limiter.
   typedef logic signed [47:0] fix_t;
endpackage : valve_travel_pkg

// ===== design/valve_travel_alert_monitor.sv
// Travel alerts, travel accumulator, cutoffs, limits, set point filter,
// rate limit and watchdog of a valve positioner.
// Assumes travel and set point arrive already ranged and synchronous to core_clk.
//
// How it works
// - Accumulate travel change only beyond accumulator deadband.
// - Move reference on increment; deadband 0 to 100%.
// - Writing zero restarts the travel total.
// - Accumulator alert when total exceeds alert point.
// - Accumulator alert holds until total reset below.
// - Four travel thresholds, -25% to 125%.
// - Threshold alert clears one deadband back past point.
// - Cutoffs force drive to maximum or minimum.
// - Beyond cutoff, opening/closing rate limits suspended.
// - Deviation alert after time above point.
// - Deviation time 1 to 60 whole seconds.
// - Deviation alert clears below point immediately.
// - Target clamped between low and high limits.
// - Set point passes first-order low-pass filter.
// - Unrearmed watchdog expiry resets whole instrument.
// - Configuration bit picks open or closed at 0%.
// - Full stroke no faster than opening/closing time.
`timescale 1ns/1ns
module valve_travel_alert_monitor
   import valve_travel_pkg::*;
#(
   parameter int TRAVEL_W = 16,
   parameter int ACC_W = 40,
   parameter int unsigned SAMPLE_TICKS = SAMPLE_CYCLES,
   parameter int unsigned WDOG_TICKS = WDOG_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Measured and requested travel
   input wire logic signed [TRAVEL_W-1:0] ranged_travel,
   input wire logic signed [TRAVEL_W-1:0] set_point,
   // Travel accumulator settings
   input wire logic [TRAVEL_W-1:0] acc_deadband,
   input wire logic [ACC_W-1:0] acc_alert_point,
   input wire logic acc_load,
   input wire logic [ACC_W-1:0] acc_load_value,
   // Travel alert settings
   input wire logic signed [TRAVEL_W-1:0] upper_point,
   input wire logic signed [TRAVEL_W-1:0] lower_point,
   input wire logic signed [TRAVEL_W-1:0] upper_critical_point,
   input wire logic signed [TRAVEL_W-1:0] lower_critical_point,
   input wire logic signed [TRAVEL_W-1:0] alert_deadband,
   // Deviation alert settings
   input wire logic [TRAVEL_W-1:0] dev_alert_point,
   input wire logic [5:0] dev_time_s,
   // Cutoffs, limits, rate and filter settings
   input wire logic signed [TRAVEL_W-1:0] cutoff_high,
   input wire logic signed [TRAVEL_W-1:0] cutoff_low,
   input wire logic signed [TRAVEL_W-1:0] limit_high,
   input wire logic signed [TRAVEL_W-1:0] limit_low,
   input wire logic [8:0] open_time_s,
   input wire logic [8:0] close_time_s,
   input wire logic [7:0] filter_time_s,
   input wire logic zero_signal_opens,
   // Watchdog
   input wire logic wdog_rearm,
   // Results
   output logic sample_tick,
   output logic signed [TRAVEL_W-1:0] target_travel,
   output logic [ACC_W-1:0] travel_total,
   output logic acc_alert,
   output logic travel_upper_alert,
   output logic travel_lower_alert,
   output logic travel_upper_critical_alert,
   output logic travel_lower_critical_alert,
   output logic dev_alert,
   output logic drive_force_max,
   output logic drive_force_min,
   output logic rate_limit_bypass,
   output logic instrument_reset
);

   // ======================================================================
   // Elaboration checks
   generate
      // Travel words must leave headroom in the 32-bit helper arithmetic, and the
      // sample period must leave at least one sample per second for the timers.
      if (TRAVEL_W < 16 || TRAVEL_W > 24
          || ACC_W < 40 || ACC_W > 46
          || SAMPLE_TICKS < 2
          || SAMPLE_TICKS > NS_PER_S / CLK_PERIOD_NS
          || WDOG_TICKS < 2) begin : g_bad_param
         $error("valve_travel_alert_monitor: unsupported parameter value");
      end
   endgenerate

   localparam int SPS = int'(NS_PER_S / (CLK_PERIOD_NS * SAMPLE_TICKS));

   // ======================================================================
   // Helpers
   function automatic int clamp(input int v, input int lo, input int hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp

   function automatic int abs_int(input int v);
      return (v < 0) ? -v : v;
   endfunction : abs_int

   function automatic fix_t to_fix(input int v);
      return fix_t'(v) <<< FRAC_BITS;
   endfunction : to_fix

   function automatic int fix_int(input fix_t v);
      return int'(signed'(v[FRAC_BITS +: 32]));
   endfunction : fix_int

   // An upper alert sets above its point and clears at point minus deadband.
   function automatic logic hyst_up(input logic act, input int x, input int pt, input int db);
      return (x > pt) ? 1'b1 : ((x <= pt - db) ? 1'b0 : act);
   endfunction : hyst_up

   function automatic logic hyst_dn(input logic act, input int x, input int pt, input int db);
      return (x < pt) ? 1'b1 : ((x >= pt + db) ? 1'b0 : act);
   endfunction : hyst_dn

   // ======================================================================
   // Sample strobe
   logic [31:0] tick_cnt;
   wire logic tick_due = (tick_cnt == 32'(SAMPLE_TICKS - 1));
   // All slow logic except the watchdog advances on this one strobe, so those timers count whole
   // samples; their lengths scale with SPS, so shrinking SAMPLE_TICKS does not shorten time.
   wire logic [31:0] next_tick_cnt = tick_due ? '0 : tick_cnt + 32'h1;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt <= '0;
         sample_tick <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         sample_tick <= tick_due;
      end
   end

   // ======================================================================
   // Clamped settings
   // Out-of-range settings are clamped rather than refused, since the block
   // has no way to report a bad value back to whoever wrote it.
   wire integer travel_i = int'(ranged_travel);
   wire integer t_db = clamp(int'(alert_deadband), TRAVEL_MIN, TRAVEL_MAX);
   wire integer t_up = clamp(int'(upper_point), TRAVEL_MIN, TRAVEL_MAX);
   wire integer t_dn = clamp(int'(lower_point), TRAVEL_MIN, TRAVEL_MAX);
   wire integer t_upc = clamp(int'(upper_critical_point), TRAVEL_MIN, TRAVEL_MAX);
   wire integer t_dnc = clamp(int'(lower_critical_point), TRAVEL_MIN, TRAVEL_MAX);
   wire integer acc_db = clamp(int'(acc_deadband), TRAVEL_ZERO, TRAVEL_FULL);
   wire integer dev_pt = clamp(int'(dev_alert_point), TRAVEL_ZERO, TRAVEL_FULL);
   wire integer dev_samples =
      clamp(int'(dev_time_s), DEV_TIME_MIN_S, DEV_TIME_MAX_S) * SPS;
   wire integer open_div = clamp(int'(open_time_s), 0, RATE_TIME_MAX_S) * SPS;
   wire integer close_div = clamp(int'(close_time_s), 0, RATE_TIME_MAX_S) * SPS;
   wire integer filt_div = int'(filter_time_s) * SPS;

   // ======================================================================
   // Set point filter and target limits
   // Zero-open mode inverts the request so that 0 % input means fully open.
   wire integer sp_eff = zero_signal_opens ? TRAVEL_FULL - int'(set_point)
      : int'(set_point);
   fix_t filt_q;
   // Coarse steps stop once the error is below filt_div / 2^16 counts; the
   // residue stays a fraction of a percent even at the longest time constant.
   wire fix_t next_filt = (filt_div == 0) ? to_fix(sp_eff)
      : filt_q + (to_fix(sp_eff) - filt_q) / fix_t'(filt_div);
   wire integer goal = clamp(fix_int(next_filt), int'(limit_low), int'(limit_high));

   // ======================================================================
   // Rate limiter
   fix_t pos_q;
   wire fix_t goal_fix = to_fix(goal);
   // Steps keep 16 fraction bits, so even the slowest stroke moves by a nonzero
   // amount each sample instead of stalling on a rounded-down step.
   wire fix_t step_up = (open_div == 0) ? '0 : to_fix(TRAVEL_FULL) / fix_t'(open_div);
   wire fix_t step_dn = (close_div == 0) ? '0 : to_fix(TRAVEL_FULL) / fix_t'(close_div);
   wire logic rising = goal_fix > pos_q;
   wire logic free_move = rate_limit_bypass || (rising ? open_div == 0 : close_div == 0);
   wire fix_t pos_up = (pos_q + step_up > goal_fix) ? goal_fix : pos_q + step_up;
   wire fix_t pos_dn = (pos_q - step_dn < goal_fix) ? goal_fix : pos_q - step_dn;
   wire fix_t next_pos = free_move ? goal_fix : (rising ? pos_up : pos_dn);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         filt_q <= '0;
         pos_q <= '0;
         target_travel <= '0;
      end else if (tick_due) begin
         filt_q <= next_filt;
         pos_q <= next_pos;
         target_travel <= TRAVEL_W'(fix_int(next_pos));
      end
   end

   // ======================================================================
   // Cutoffs
   // The force outputs follow the same sample as the alerts, so a valve that
   // just crosses a cutoff is forced at most one sample period later.
   wire logic beyond_high = travel_i > int'(cutoff_high);
   wire logic beyond_low = travel_i < int'(cutoff_low);

   wire logic next_force_max = zero_signal_opens ? beyond_low : beyond_high;
   wire logic next_force_min = zero_signal_opens ? beyond_high : beyond_low;
   wire logic next_bypass = beyond_high || beyond_low;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         drive_force_max <= 1'b0;
         drive_force_min <= 1'b0;
         rate_limit_bypass <= 1'b0;
      end else if (tick_due) begin
         drive_force_max <= next_force_max;
         drive_force_min <= next_force_min;
         rate_limit_bypass <= next_bypass;
      end
   end

   // ======================================================================
   // Travel accumulator
   logic signed [TRAVEL_W-1:0] acc_ref;
   wire integer acc_step = abs_int(travel_i - int'(acc_ref));
   wire logic acc_take = tick_due && (acc_step > acc_db);
   // A load wins over a sample in the same cycle; that sample's movement is
   // dropped rather than added on top of the freshly written total.
   wire logic [ACC_W-1:0] next_total = acc_load ? acc_load_value
      : (acc_take ? travel_total + ACC_W'(acc_step) : travel_total);
   // The reference moves only when a step is counted or a total is loaded, so slow creep below the
   // deadband still adds up once it has gathered past the deadband.
   wire logic signed [TRAVEL_W-1:0] next_acc_ref = (acc_load || acc_take) ? ranged_travel
      : acc_ref;
   // The total is wide enough for the largest alert point; past that it wraps
   // silently, so an operator is expected to clear it long before.

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         travel_total <= '0;
         acc_ref <= '0;
      end else begin
         travel_total <= next_total;
         acc_ref <= next_acc_ref;
      end
   end

   // ======================================================================
   // Travel and accumulator alerts
   // The accumulator alert looks at the total written in this same sample, so
   // the step that crosses the point raises it at once. An equal total holds.
   wire logic acc_above = next_total > acc_alert_point;
   wire logic acc_below = next_total < acc_alert_point;
   wire logic next_acc_alert = acc_above || (acc_alert && !acc_below);

   // A deadband of zero or less clears an alert as soon as travel is back on
   // its own side of the point; the clamp keeps the sum inside 32 bits.
   wire logic next_upper = hyst_up(travel_upper_alert, travel_i, t_up, t_db);
   wire logic next_lower = hyst_dn(travel_lower_alert, travel_i, t_dn, t_db);
   wire logic next_upper_critical =
      hyst_up(travel_upper_critical_alert, travel_i, t_upc, t_db);
   wire logic next_lower_critical =
      hyst_dn(travel_lower_critical_alert, travel_i, t_dnc, t_db);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_alert <= 1'b0;
      end else if (tick_due) begin
         acc_alert <= next_acc_alert;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         travel_upper_alert <= 1'b0;
         travel_lower_alert <= 1'b0;
         travel_upper_critical_alert <= 1'b0;
         travel_lower_critical_alert <= 1'b0;
      end else if (tick_due) begin
         travel_upper_alert <= next_upper;
         travel_lower_alert <= next_lower;
         travel_upper_critical_alert <= next_upper_critical;
         travel_lower_critical_alert <= next_lower_critical;
      end
   end

   // ======================================================================
   // Deviation alert
   // The difference is taken against the target registered at the previous
   // sample, which is the position the valve was last asked to reach.
   wire integer dev_mag = abs_int(int'(target_travel) - travel_i);
   logic [31:0] dev_cnt;

   wire logic dev_over = dev_mag > dev_pt;
   wire logic dev_under = dev_mag < dev_pt;
   wire logic dev_timed = dev_cnt >= 32'(dev_samples);
   wire logic next_dev_alert = (dev_over && dev_timed)
      || (dev_alert && !dev_under);
   // Counting stops once the time is qualified, so the counter never wraps
   // however long the deviation lasts.
   wire logic [31:0] next_dev_cnt = dev_under ? '0
      : ((dev_over && !dev_timed) ? dev_cnt + 32'h1 : dev_cnt);
   // A shorter sample period stretches the deviation time in samples, so a
   // bench that shrinks SAMPLE_TICKS cannot reach this alert in a short run.

   // The deviation point is the user's choice; 5 % is only a suggestion.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         dev_cnt <= '0;
         dev_alert <= 1'b0;
      end else if (tick_due) begin
         dev_cnt <= next_dev_cnt;
         dev_alert <= next_dev_alert;
      end
   end

   // ======================================================================
   // Watchdog
   // The counter is 32 bits so the default timeout fits with a wide margin.
   logic [31:0] wdog_cnt;
   wire logic wdog_due = (wdog_cnt == 32'(WDOG_TICKS - 1));
   // A rearm in the very cycle of expiry still counts, so a processor that is
   // late by only the last cycle does not reset the instrument.
   wire logic [31:0] next_wdog_cnt = (wdog_rearm || wdog_due) ? '0 : wdog_cnt + 32'h1;
   wire logic next_instrument_reset = wdog_due && !wdog_rearm;
   // Expiry only pulses the reset output; this block's own state is left for
   // the instrument-wide reset that the pulse triggers.

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wdog_cnt <= '0;
         instrument_reset <= 1'b0;
      end else begin
         wdog_cnt <= next_wdog_cnt;
         instrument_reset <= next_instrument_reset;
      end
   end

endmodule : valve_travel_alert_monitor

// ===== bench/travel_sensor_model.sv
// Stand-in for the travel sensor and the analog set point source.
// Assumes the bench changes the commanded values only at the falling clock edge.
`timescale 1ns/1ns
// ==========
// Sensor model
module travel_sensor_model #(
   parameter int W = 16
) (
   // Commanded values
   input wire logic signed [W-1:0] pos_cmd,
   input wire logic signed [W-1:0] sp_cmd,
   // Readings
   output logic signed [W-1:0] ranged_travel,
   output logic signed [W-1:0] set_point
);
   // An ideal sensor follows at once, so all sample timing stays with the bench.
   assign ranged_travel = pos_cmd;
   assign set_point = sp_cmd;
endmodule : travel_sensor_model

// ===== bench/travel_alert_monitor.sv
// Port checker for the valve travel alert monitor, bound to its top module.
// Assumes one clock domain and settings held steady around each sample.
`timescale 1ns/1ns
// ==========
// Checker
module travel_alert_checker #(
   parameter int TRAVEL_W = 16,
   parameter int ACC_W = 40
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Inputs watched
   input wire logic signed [TRAVEL_W-1:0] ranged_travel,
   input wire logic signed [TRAVEL_W-1:0] upper_point,
   input wire logic signed [TRAVEL_W-1:0] alert_deadband,
   input wire logic signed [TRAVEL_W-1:0] cutoff_high,
   input wire logic signed [TRAVEL_W-1:0] cutoff_low,
   input wire logic zero_signal_opens,
   input wire logic acc_load,
   input wire logic [ACC_W-1:0] acc_load_value,
   input wire logic [ACC_W-1:0] acc_alert_point,
   input wire logic wdog_rearm,
   // Results
   input wire logic sample_tick,
   input wire logic signed [TRAVEL_W-1:0] target_travel,
   input wire logic [ACC_W-1:0] travel_total,
   input wire logic acc_alert,
   input wire logic travel_upper_alert,
   input wire logic drive_force_max,
   input wire logic drive_force_min,
   input wire logic rate_limit_bypass,
   input wire logic instrument_reset
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   a_tick_single: assert property (sample_tick |=> !sample_tick)
      else $error("sample tick longer than one cycle");
   a_results_hold:
      assert property (!sample_tick |-> $stable({travel_upper_alert, drive_force_max, target_travel}))
      else $error("result changed between samples");
   a_upper_set:
      assert property (sample_tick && $past(ranged_travel) > $past(upper_point) |-> travel_upper_alert)
      else $error("upper alert missing above its point");
   a_upper_clear:
      assert property (sample_tick && $past(ranged_travel) <= $past(upper_point) - $past(alert_deadband)
         && $past(ranged_travel) <= $past(upper_point) |-> !travel_upper_alert)
      else $error("upper alert kept past its deadband");
   a_cutoff_max:
      assert property (sample_tick |-> drive_force_max == ($past(zero_signal_opens) ?
         $past(ranged_travel) < $past(cutoff_low) : $past(ranged_travel) > $past(cutoff_high)))
      else $error("drive maximum disagrees with cutoffs");
   a_cutoff_min:
      assert property (sample_tick |-> drive_force_min == ($past(zero_signal_opens) ?
         $past(ranged_travel) > $past(cutoff_high) : $past(ranged_travel) < $past(cutoff_low)))
      else $error("drive minimum disagrees with cutoffs");
   a_bypass_either: assert property (rate_limit_bypass == (drive_force_max || drive_force_min))
      else $error("rate bypass disagrees with cutoff state");
   a_total_load: assert property (acc_load |=> travel_total == $past(acc_load_value))
      else $error("travel total not loaded");
   a_acc_alert_set:
      assert property ($rose(acc_alert) && !$past(acc_load) |-> travel_total > acc_alert_point)
      else $error("accumulator alert without total above point");
   a_wdog_lapse:
      assert property (instrument_reset |-> !$past(wdog_rearm) && !$past(wdog_rearm, 2))
      else $error("watchdog fired despite rearm");
   a_reset_pulse: assert property (instrument_reset |=> !instrument_reset)
      else $error("instrument reset longer than one cycle");
   c_upper: cover property (sample_tick && travel_upper_alert);
   c_acc: cover property ($rose(acc_alert));
   c_wdog: cover property (instrument_reset);
endmodule : travel_alert_checker
bind valve_travel_alert_monitor travel_alert_checker #(.TRAVEL_W(TRAVEL_W), .ACC_W(ACC_W)) chk (
   .core_clk, .arst_n, .ranged_travel, .upper_point, .alert_deadband, .cutoff_high, .cutoff_low,
   .zero_signal_opens, .acc_load, .acc_load_value, .acc_alert_point, .wdog_rearm, .sample_tick,
   .target_travel, .travel_total, .acc_alert, .travel_upper_alert, .drive_force_max,
   .drive_force_min, .rate_limit_bypass, .instrument_reset);

// ===== bench/tb_top.sv
// Self-checking bench for the valve travel alert monitor.
// Assumes short sample and watchdog counts; rate limit and filter left off.
`timescale 1ns/1ns
// ==========
// Bench
module tb_top;
   localparam int ST = 20;
   localparam int WD = 50;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic signed [15:0] pos = 16'h1388, sp = 16'h1388, ranged_travel, set_point;
   logic [15:0] acc_deadband = 16'h03E8, dev_alert_point = 16'h2710;
   logic [39:0] acc_alert_point = 40'h00000005DC, acc_load_value = 40'h0;
   logic signed [15:0] upper_point = 16'h1F40, lower_point = 16'h07D0, alert_deadband = 16'h01F4;
   logic signed [15:0] upper_critical_point = 16'h2328, lower_critical_point = 16'h03E8;
   logic signed [15:0] cutoff_high = 16'h2648, cutoff_low = 16'h00C8;
   logic signed [15:0] limit_high = 16'h2328, limit_low = 16'h03E8, target_travel;
   logic [5:0] dev_time_s = 6'h01;
   logic [8:0] open_time_s = 9'h000, close_time_s = 9'h000;
   logic [7:0] filter_time_s = 8'h00;
   logic acc_load = 1'b0, zero_signal_opens = 1'b0, wdog_rearm = 1'b1;
   logic sample_tick, acc_alert, travel_upper_alert, travel_lower_alert, dev_alert;
   logic travel_upper_critical_alert, travel_lower_critical_alert, instrument_reset;
   logic drive_force_max, drive_force_min, rate_limit_bypass;
   logic [39:0] travel_total;
   int failures = 0, compares = 0, cyc = 0;
   always #5 core_clk = ~core_clk;
   travel_sensor_model sensor (.pos_cmd(pos), .sp_cmd(sp), .ranged_travel, .set_point);
   valve_travel_alert_monitor #(.SAMPLE_TICKS(ST), .WDOG_TICKS(WD)) dut (.core_clk, .arst_n,
      .ranged_travel, .set_point, .acc_deadband, .acc_alert_point, .acc_load, .acc_load_value,
      .upper_point, .lower_point, .upper_critical_point, .lower_critical_point, .alert_deadband,
      .dev_alert_point, .dev_time_s, .cutoff_high, .cutoff_low, .limit_high, .limit_low,
      .open_time_s, .close_time_s, .filter_time_s, .zero_signal_opens, .wdog_rearm, .sample_tick,
      .target_travel, .travel_total, .acc_alert, .travel_upper_alert, .travel_lower_alert,
      .travel_upper_critical_alert, .travel_lower_critical_alert, .dev_alert, .drive_force_max,
      .drive_force_min, .rate_limit_bypass, .instrument_reset);
   task automatic conclude;
      if (failures == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Returns at the falling edge just after a sample has landed.
   task automatic smp;
      int n;
      n = 0;
      @(negedge core_clk);
      while (sample_tick !== 1'b1 && n < 50) begin
         @(negedge core_clk);
         n++;
      end
   endtask : smp
   task automatic row(input logic [15:0] t, input logic [15:0] s, input logic z,
      input logic [3:0] a, input logic [1:0] f, input logic [15:0] g);
      pos = t;
      sp = s;
      zero_signal_opens = z;
      smp();
      chk("alerts", {travel_upper_critical_alert, travel_upper_alert, travel_lower_alert,
         travel_lower_critical_alert}, {36'h0, a});
      chk("force", {38'h0, drive_force_max, drive_force_min}, {38'h0, f});
      chk("bypass", {39'h0, rate_limit_bypass}, {39'h0, |f});
      chk("target", {24'h0, target_travel}, {24'h0, g});
      chk("deviation", {39'h0, dev_alert}, 40'h0);
   endtask : row
   task automatic ld(input logic [39:0] v);
      acc_load_value = v;
      acc_load = 1'b1;
      @(negedge core_clk);
      acc_load = 1'b0;
      chk("loaded total", travel_total, v);
   endtask : ld
   task automatic acc(input logic [15:0] t, input logic [39:0] tot, input logic al);
      pos = t;
      smp();
      chk("total", travel_total, tot);
      chk("acc alert", {39'h0, acc_alert}, {39'h0, al});
   endtask : acc
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      int n;
      n = 0;
      repeat (8) @(negedge core_clk);
      chk("reset outputs", {32'h0, sample_tick, acc_alert, travel_upper_alert, dev_alert,
         drive_force_max, drive_force_min, rate_limit_bypass, instrument_reset}, 40'h0);
      arst_n = 1'b1;
      row(16'h1388, 16'h1388, 1'b0, 4'h0, 2'h0, 16'h1388);
      row(16'h2134, 16'h2AF8, 1'b0, 4'h4, 2'h0, 16'h2328);
      row(16'h1E78, 16'hFE0C, 1'b0, 4'h4, 2'h0, 16'h03E8);
      row(16'h1D4C, 16'h1388, 1'b0, 4'h0, 2'h0, 16'h1388);
      row(16'h251C, 16'h1388, 1'b0, 4'hC, 2'h0, 16'h1388);
      row(16'h05DC, 16'h1388, 1'b0, 4'h2, 2'h0, 16'h1388);
      row(16'h0960, 16'h1388, 1'b0, 4'h2, 2'h0, 16'h1388);
      row(16'h01F4, 16'h1388, 1'b0, 4'h3, 2'h0, 16'h1388);
      row(16'h09C4, 16'h1388, 1'b0, 4'h0, 2'h0, 16'h1388);
      row(16'h0064, 16'h1388, 1'b0, 4'h3, 2'h1, 16'h1388);
      row(16'h26AC, 16'h1388, 1'b0, 4'hC, 2'h2, 16'h1388);
      row(16'h26AC, 16'h0BB8, 1'b1, 4'hC, 2'h1, 16'h1B58);
      pos = 16'h1388;
      smp();
      ld(40'h0);
      acc(16'h16A8, 40'h0, 1'b0);
      acc(16'h1770, 40'h0, 1'b0);
      acc(16'h17D4, 40'h44C, 1'b0);
      acc(16'h1E14, 40'hA8C, 1'b1);
      ld(40'h5DC);
      acc(16'h1E14, 40'h5DC, 1'b1);
      ld(40'h0);
      acc(16'h1E14, 40'h0, 1'b0);
      wdog_rearm = 1'b0;
      while (instrument_reset !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      chk("watchdog cycles", n, WD);
      @(negedge core_clk);
      chk("watchdog pulse", {39'h0, instrument_reset}, 40'h0);
      wdog_rearm = 1'b1;
      conclude();
   end
endmodule : tb_top
